/* logic/xeu_defs.vh */
// constants for the extended instruction execution unit
`ifndef XEU_DEFS_VH
`define XEU_DEFS_VH
// register byte offsets
`define XEU_OFS_CMD      8'h00
`define XEU_OFS_ACC      8'h04
`define XEU_OFS_STATUS   8'h08
`define XEU_OFS_TBLPTR   8'h0c
`define XEU_OFS_TBLHIGH  8'h10
`define XEU_OFS_PC       8'h14
`define XEU_OFS_DMADDR   8'h18
`define XEU_OFS_DMDATA   8'h1c
`define XEU_OFS_PMADDR   8'h20
`define XEU_OFS_PMDATA   8'h24
// status fields
`define XEU_ST_C     0
`define XEU_ST_AC    1
`define XEU_ST_Z     2
`define XEU_ST_OV    3
`define XEU_ST_SC    4
`define XEU_ST_CZ    5
`define XEU_ST_SKIP  6
`define XEU_ST_BUSY  7
// command fields
`define XEU_CMD_OP   4:0
`define XEU_CMD_BIT  7:5
`define XEU_CMD_ADR  15:8
// opcodes
`define XEU_OP_DSZ    5'h00
`define XEU_OP_DSZA   5'h01
`define XEU_OP_SET    5'h02
`define XEU_OP_SETB   5'h03
`define XEU_OP_ISZ    5'h04
`define XEU_OP_ISZA   5'h05
`define XEU_OP_SNZB   5'h06
`define XEU_OP_SNZ    5'h07
`define XEU_OP_SUB    5'h08
`define XEU_OP_SUBM   5'h09
`define XEU_OP_SWAP   5'h0a
`define XEU_OP_SWAPA  5'h0b
`define XEU_OP_SZ     5'h0c
`define XEU_OP_SZA    5'h0d
`define XEU_OP_SZB    5'h0e
`define XEU_OP_TRD    5'h0f
`define XEU_OP_TRDL   5'h10
`define XEU_OP_ITRD   5'h11
`define XEU_OP_ITRDL  5'h12
`define XEU_OP_XOR    5'h13
`define XEU_OP_XORM   5'h14
// reset values and constants
`define XEU_RST_BYTE  8'h00
`define XEU_RST_PC    12'h000
`define XEU_ALL_ONES  8'hff
`define XEU_LAST_PAGE 4'hf
`endif

/* logic/xeu_exec_unit.v */
// extended data-memory instruction execution unit with ahb-lite register access
// Operation
// (RULE1) decrement memory, writeback, skip on zero
// (RULE2) decrement into accumulator, skip on zero
// (RULE3) byte set writes all ones
// (RULE4) bit set touches selected bit only
// (RULE5) increment memory, writeback, skip on zero
// (RULE6) increment into accumulator, skip on zero
// (RULE7) skip when selected bit is one
// (RULE8) skip when byte is non-zero
// (RULE9) acc minus memory into acc, six flags
// (RULE10) acc minus memory into memory, six flags
// (RULE11) swap nibbles of memory in place
// (RULE12) swapped nibbles into accumulator
// (RULE13) skip when byte is zero
// (RULE14) copy byte to acc, skip on zero
// (RULE15) skip when selected bit is zero
// (RULE16) table read within current page
// (RULE17) table read within last page
// (RULE18) bump pointer low, read full pointer address; the code uses only the low nibble of the high pointer byte
// (RULE19) bump pointer low, read last page
// (RULE20) xor into acc, zero flag only
// (RULE21) xor into memory, zero flag only
// (RULE22) one cycle unless skip adds dummy
`timescale 1ns/100ps
`include "xeu_defs.vh"
module xeu_exec_unit (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata
);
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_EXEC  = 2'd1;
  localparam [1:0] ST_DUMMY = 2'd2;

  reg [7:0]  dmem [0:255];
  reg [15:0] pmem [0:4095];

  reg        dp_valid_q;
  reg        dp_write_q;
  reg [7:0]  dp_addr_q;
  reg [1:0]  state_q;
  reg [15:0] cmd_q;
  reg [7:0]  acc_q;
  reg [5:0]  flags_q;
  reg        skip_q;
  reg [7:0]  table_ptr_low_q;
  reg [7:0]  table_ptr_high_q;
  reg [7:0]  table_read_high_byte_q;
  reg [11:0] pc_q;
  reg [7:0]  dm_addr_q;
  reg [11:0] pm_addr_q;
  reg        rd_done_q;
  reg [31:0] rd_mux;

  // exec results
  reg [7:0]  mem_res;
  reg        mem_wr;
  reg [7:0]  acc_res;
  reg        acc_wr;
  reg [5:0]  flags_res;
  reg        skip_res;
  reg [7:0]  tlo_res;
  reg        tbl_wr;
  reg [11:0] tbl_addr;
  reg [8:0]  sub_full;
  reg [4:0]  sub_nib;
  reg [7:0]  sub_res;
  reg        sub_ov;

  wire [4:0]  op      = cmd_q[`XEU_CMD_OP];
  wire [2:0]  bsel    = cmd_q[`XEU_CMD_BIT];
  wire [7:0]  madr    = cmd_q[`XEU_CMD_ADR];
  wire [7:0]  mval    = dmem[madr];
  wire [7:0]  dec_val = mval - 8'h01;
  wire [7:0]  inc_val = mval + 8'h01;
  wire [7:0]  xor_val = acc_q ^ mval;
  wire [7:0]  tlo_inc = table_ptr_low_q + 8'h01;
  wire [7:0]  bit_msk = 8'h01 << bsel;
  wire [15:0] tword   = pmem[tbl_addr];
  wire        busy    = (state_q != ST_IDLE);
  wire        wr_en   = dp_valid_q & dp_write_q & ~busy;
  wire        rd_load = dp_valid_q & ~dp_write_q & ~busy & ~rd_done_q;

  // stall a data phase that meets a running instruction, and every read for
  // one cycle so that read data leaves from a flop holding settled contents
  assign hreadyout = ~(dp_valid_q & (busy | (~dp_write_q & ~rd_done_q)));
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= `XEU_RST_BYTE;
    end
    else if (hready)
    begin
      dp_valid_q <= hsel & htrans[1];
      dp_write_q <= hwrite;
      dp_addr_q  <= haddr[7:0];
    end
  end

  always @*
  begin
    sub_full  = {1'b0, acc_q} - {1'b0, mval};
    sub_nib   = {1'b0, acc_q[3:0]} - {1'b0, mval[3:0]};
    sub_res   = sub_full[7:0];
    sub_ov    = (acc_q[7] ^ mval[7]) & (acc_q[7] ^ sub_res[7]);
    mem_res   = mval;
    mem_wr    = 1'b0;
    acc_res   = acc_q;
    acc_wr    = 1'b0;
    flags_res = flags_q;
    skip_res  = 1'b0;
    tlo_res   = table_ptr_low_q;
    tbl_wr    = 1'b0;
    tbl_addr  = {pc_q[11:8], table_ptr_low_q};
    case (op)
      `XEU_OP_DSZ:
      begin
        mem_res  = dec_val;  // [RULE1]
        mem_wr   = 1'b1;
        skip_res = (dec_val == 8'h00);
      end
      `XEU_OP_DSZA:
      begin
        acc_res  = dec_val;  // [RULE2]
        acc_wr   = 1'b1;
        skip_res = (dec_val == 8'h00);
      end
      `XEU_OP_SET:
      begin
        mem_res = `XEU_ALL_ONES;  // [RULE3]
        mem_wr  = 1'b1;
      end
      `XEU_OP_SETB:
      begin
        mem_res = mval | bit_msk;  // [RULE4]
        mem_wr  = 1'b1;
      end
      `XEU_OP_ISZ:
      begin
        mem_res  = inc_val;  // [RULE5]
        mem_wr   = 1'b1;
        skip_res = (inc_val == 8'h00);
      end
      `XEU_OP_ISZA:
      begin
        acc_res  = inc_val;  // [RULE6]
        acc_wr   = 1'b1;
        skip_res = (inc_val == 8'h00);
      end
      `XEU_OP_SNZB:
        skip_res = mval[bsel];  // [RULE7]
      `XEU_OP_SNZ:
        skip_res = (mval != 8'h00);  // [RULE8]
      `XEU_OP_SUB, `XEU_OP_SUBM:
      begin
        // carry means no borrow; cz equals z since no carry-in is used
        flags_res[`XEU_ST_C]  = ~sub_full[8];  // [RULE9] [RULE10]
        flags_res[`XEU_ST_AC] = ~sub_nib[4];
        flags_res[`XEU_ST_Z]  = (sub_res == 8'h00);
        flags_res[`XEU_ST_OV] = sub_ov;
        flags_res[`XEU_ST_SC] = sub_ov ^ sub_res[7];
        flags_res[`XEU_ST_CZ] = (sub_res == 8'h00);
        if (op == `XEU_OP_SUB)
        begin
          acc_res = sub_res;  // [RULE9]
          acc_wr  = 1'b1;
        end
        else
        begin
          mem_res = sub_res;  // [RULE10]
          mem_wr  = 1'b1;
        end
      end
      `XEU_OP_SWAP:
      begin
        mem_res = {mval[3:0], mval[7:4]};  // [RULE11]
        mem_wr  = 1'b1;
      end
      `XEU_OP_SWAPA:
      begin
        acc_res = {mval[3:0], mval[7:4]};  // [RULE12]
        acc_wr  = 1'b1;
      end
      `XEU_OP_SZ:
        skip_res = (mval == 8'h00);  // [RULE13]
      `XEU_OP_SZA:
      begin
        acc_res  = mval;  // [RULE14]
        acc_wr   = 1'b1;
        skip_res = (mval == 8'h00);
      end
      `XEU_OP_SZB:
        skip_res = ~mval[bsel];  // [RULE15]
      `XEU_OP_TRD:
      begin
        tbl_addr = {pc_q[11:8], table_ptr_low_q};  // [RULE16]
        tbl_wr   = 1'b1;
      end
      `XEU_OP_TRDL:
      begin
        tbl_addr = {`XEU_LAST_PAGE, table_ptr_low_q};  // [RULE17]
        tbl_wr   = 1'b1;
      end
      `XEU_OP_ITRD:
      begin
        // only the low nibble of the high pointer fits the 4k word space
        tlo_res  = tlo_inc;  // [RULE18]
        tbl_addr = {table_ptr_high_q[3:0], tlo_inc};
        tbl_wr   = 1'b1;
      end
      `XEU_OP_ITRDL:
      begin
        tlo_res  = tlo_inc;  // [RULE19]
        tbl_addr = {`XEU_LAST_PAGE, tlo_inc};
        tbl_wr   = 1'b1;
      end
      `XEU_OP_XOR:
      begin
        acc_res = xor_val;  // [RULE20]
        acc_wr  = 1'b1;
        flags_res[`XEU_ST_Z] = (xor_val == 8'h00);
      end
      `XEU_OP_XORM:
      begin
        mem_res = xor_val;  // [RULE21]
        mem_wr  = 1'b1;
        flags_res[`XEU_ST_Z] = (xor_val == 8'h00);
      end
      default:
        skip_res = 1'b0;
    endcase
    if (tbl_wr)
    begin
      mem_res = tword[7:0];  // [RULE16] [RULE17] [RULE18] [RULE19]
      mem_wr  = 1'b1;
    end
  end

  // data memory: a bus write and an execute never meet since the bus stalls
  always @(posedge hclk)
  begin
    if (state_q == ST_EXEC && mem_wr)
      dmem[madr] <= mem_res;
    else if (wr_en && dp_addr_q == `XEU_OFS_DMDATA)
      dmem[dm_addr_q] <= hwdata[7:0];
  end

  always @(posedge hclk)
  begin
    if (wr_en && dp_addr_q == `XEU_OFS_PMDATA)
      pmem[pm_addr_q] <= hwdata[15:0];
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q                <= ST_IDLE;
      cmd_q                  <= 16'h0000;
      acc_q                  <= `XEU_RST_BYTE;
      flags_q                <= 6'h00;
      skip_q                 <= 1'b0;
      table_ptr_low_q        <= `XEU_RST_BYTE;
      table_ptr_high_q       <= `XEU_RST_BYTE;
      table_read_high_byte_q <= `XEU_RST_BYTE;
      pc_q                   <= `XEU_RST_PC;
      dm_addr_q              <= `XEU_RST_BYTE;
      pm_addr_q              <= 12'h000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (wr_en)
          begin
            case (dp_addr_q)
              `XEU_OFS_CMD:
              begin
                cmd_q   <= hwdata[15:0];
                state_q <= ST_EXEC;
              end
              `XEU_OFS_ACC:
                acc_q <= hwdata[7:0];
              `XEU_OFS_STATUS:
                flags_q <= hwdata[5:0];
              `XEU_OFS_TBLPTR:
              begin
                table_ptr_low_q  <= hwdata[7:0];
                table_ptr_high_q <= hwdata[15:8];
              end
              `XEU_OFS_PC:
                pc_q <= hwdata[11:0];
              `XEU_OFS_DMADDR:
                dm_addr_q <= hwdata[7:0];
              `XEU_OFS_PMADDR:
                pm_addr_q <= hwdata[11:0];
              default:
                state_q <= ST_IDLE;
            endcase
          end
        end
        ST_EXEC:
        begin
          if (acc_wr)
            acc_q <= acc_res;
          flags_q         <= flags_res;
          table_ptr_low_q <= tlo_res;
          if (tbl_wr)
            table_read_high_byte_q <= tword[15:8];
          skip_q <= skip_res;
          // a taken skip steps over the next word and costs a dummy cycle
          pc_q    <= pc_q + (skip_res ? 12'h002 : 12'h001);  // [RULE22]
          state_q <= skip_res ? ST_DUMMY : ST_IDLE;  // [RULE22]
        end
        ST_DUMMY:
          state_q <= ST_IDLE;  // [RULE22]
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (dp_addr_q)
      `XEU_OFS_CMD:     rd_mux = {16'h0000, cmd_q};
      `XEU_OFS_ACC:     rd_mux = {24'h00_0000, acc_q};
      `XEU_OFS_STATUS:  rd_mux = {24'h00_0000, busy, skip_q, flags_q};
      `XEU_OFS_TBLPTR:  rd_mux = {16'h0000, table_ptr_high_q, table_ptr_low_q};
      `XEU_OFS_TBLHIGH: rd_mux = {24'h00_0000, table_read_high_byte_q};
      `XEU_OFS_PC:      rd_mux = {20'h0_0000, pc_q};
      `XEU_OFS_DMADDR:  rd_mux = {24'h00_0000, dm_addr_q};
      `XEU_OFS_DMDATA:  rd_mux = {24'h00_0000, dmem[dm_addr_q]};
      `XEU_OFS_PMADDR:  rd_mux = {20'h0_0000, pm_addr_q};
      `XEU_OFS_PMDATA:  rd_mux = {16'h0000, pmem[pm_addr_q]};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is loaded once the unit is idle in the read data phase, after
  // any write or execution has landed, and cleared as the phase ends so no
  // stale word lingers on the bus
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done_q <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else if (hready)
    begin
      rd_done_q <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else if (rd_load)
    begin
      rd_done_q <= 1'b1;
      hrdata    <= rd_mux;
    end
  end
endmodule // xeu_exec_unit

/* verif/xeu_exec_unit_chk.sv */
// bus-level checker for the extended instruction unit
`timescale 1ns/100ps
module xeu_exec_unit_chk (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata
);
  logic       tk;
  logic       cw_q;
  logic       rd_q;
  logic       dp_q;
  logic [7:0] a_q;
  assign tk = hsel && htrans[1] && hready;
  // data-phase view of the last accepted address phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cw_q <= 1'b0;
      rd_q <= 1'b0;
      dp_q <= 1'b0;
      a_q  <= 8'h00;
    end
    else if (hready)
    begin
      cw_q <= tk && hwrite && haddr[7:0] == 8'h00;
      rd_q <= tk && !hwrite;
      dp_q <= tk;
      a_q  <= haddr[7:0];
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  property p_stall;
    cw_q ##1 (tk && !hwrite) |=> !hreadyout ##1 (hreadyout or (!hreadyout ##1 hreadyout));
  endproperty
  property p_short; $fell(hreadyout) |-> ##[1:3] hreadyout; endproperty
  property p_cmd_rdy; cw_q |-> hreadyout; endproperty
  property p_idle; !hreadyout |-> dp_q; endproperty
  property p_unmap; rd_q && hreadyout && a_q > 8'h24 |-> hrdata == 32'h0000_0000; endproperty
  property p_acc_hi; rd_q && hreadyout && a_q == 8'h04 |-> hrdata[31:8] == 24'h00_0000;
  endproperty
  property p_busy; rd_q && hreadyout && a_q == 8'h08 |-> hrdata[31:7] == 25'h000_0000;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  a_stall: assert property (p_stall) else $error("wrong stall after command");
  a_short: assert property (p_short) else $error("stall too long");
  a_cmd_rdy: assert property (p_cmd_rdy) else $error("command write stalled");
  a_idle: assert property (p_idle) else $error("stall outside data phase");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_acc_hi: assert property (p_acc_hi) else $error("accumulator upper bits set");
  a_busy: assert property (p_busy) else $error("status busy or upper bits set");
  cover property (cw_q ##1 tk);
  cover property ($fell(hreadyout) ##2 hreadyout);
  cover property (rd_q && hreadyout && a_q == 8'h10);
endmodule // xeu_exec_unit_chk
bind xeu_exec_unit xeu_exec_unit_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

/* verif/tb_xeu_exec_unit.sv */
// self-checking bench for the extended instruction unit
`timescale 1ns/100ps
module tb_xeu_exec_unit;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [63:0] r;
  logic [63:0] rows [19];
  logic [15:0] tw [4];
  logic [15:0] td [4];
  int          error_cnt;
  int          tests_run;
  xeu_exec_unit i_dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (1'b1),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata)
  );
  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // sample mid-cycle so the value seen is the one present at the next edge
  task automatic wt(output logic [31:0] q);
    int   n;
    logic k;
    n = 0;
    do
    begin
      @(negedge hclk);
      k = hreadyout;
      q = hrdata;
      @(posedge hclk);
      n++;
    end
    while (k !== 1'b1 && n < 40);
    if (k !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL %0t bus hang", $time);
      conclude;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    haddr  <= 32'(a);
    hwrite <= w;
    htrans <= 2'h2;
    wt(d);
    htrans <= 2'h0;
    hwdata <= v;
    wt(d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    tests_run++;
    if (d !== e)
    begin
      error_cnt++;
      $display("FAIL %0t at %h got %h exp %h", $time, a, d, e);
    end
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    hresetn = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    error_cnt = 0;
    tests_run = 0;
    // op, bit, status before, mem, acc, mem after, acc after, status after
    rows = '{64'h0000_2a01_5500_556a,
             64'h0100_2a00_5500_ff2a,
             64'h0200_2a12_55ff_552a,
             64'h0305_2a00_5520_552a,
             64'h0400_2aff_5500_556a,
             64'h0500_2a7f_557f_802a,
             64'h0603_2a08_5508_556a,
             64'h0700_2a00_5500_552a,
             64'h0800_2a01_0001_ff10,
             64'h0800_0005_0505_0027,
             64'h0900_2a80_0181_010a,
             64'h0a00_2aa5_555a_552a,
             64'h0b00_2aa5_55a5_5a2a,
             64'h0c00_2a00_5500_556a,
             64'h0d00_2a00_5500_006a,
             64'h0e02_2afb_55fb_556a,
             64'h1300_2a55_5555_002e,
             64'h1400_040f_555a_5500,
             64'h1f00_2a33_5533_552a};
    tw = '{16'h0134, 16'h0f34, 16'h0735, 16'h0f36};
    td = '{16'hbeef, 16'hcafe, 16'h1234, 16'h5678};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h08, 32'h0000_0000);
    foreach (rows[i])
    begin
      r = rows[i];
      xfer(1'b1, 8'h04, 32'(r[31:24]));
      xfer(1'b1, 8'h18, 32'h0000_0040);
      xfer(1'b1, 8'h1c, 32'(r[39:32]));
      xfer(1'b1, 8'h08, 32'(r[47:40]));
      xfer(1'b1, 8'h14, 32'h0000_00ff);
      xfer(1'b1, 8'h00, {16'h0000, 8'h40, r[50:48], r[60:56]});
      rc(8'h04, 32'(r[15:8]));
      rc(8'h1c, 32'(r[23:16]));
      rc(8'h08, 32'(r[7:0]));
      rc(8'h14, 32'h0000_0100 + 32'(r[6]));
    end
    foreach (tw[i])
    begin
      xfer(1'b1, 8'h20, 32'(tw[i]));
      xfer(1'b1, 8'h24, 32'(td[i]));
    end
    xfer(1'b1, 8'h0c, 32'h0000_0734);
    xfer(1'b1, 8'h14, 32'h0000_01f0);
    foreach (tw[i])
    begin
      xfer(1'b1, 8'h00, {16'h0000, 8'h40, 3'h0, 5'h0f + 5'(i)});
      // high byte holder is read-only, this write must vanish
      xfer(1'b1, 8'h10, 32'h0000_00aa);
      rc(8'h1c, 32'(td[i][7:0]));
      rc(8'h10, 32'(td[i][15:8]));
      rc(8'h0c, 32'h0000_0734 + 32'(i > 1) + 32'(i > 2));
    end
    xfer(1'b1, 8'h30, 32'h1234_5678);
    rc(8'h30, 32'h0000_0000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h04, 32'h0000_0000);
    rc(8'h0c, 32'h0000_0000);
    conclude;
  end
endmodule // tb_xeu_exec_unit
